// ==== crps_pkg.sv ====
package crps_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_GEN_MASK = 8'h17;
	localparam logic [7:0] ADDR_POWER_ON = 8'h19;
	localparam logic [7:0] ADDR_CH_RESET = 8'h1A;
	localparam logic [7:0] ADDR_POL2P_CH1 = 8'h1E;
	localparam logic [7:0] ADDR_POL2P_CH2 = 8'h1F;
	localparam logic [7:0] ADDR_POL2P_CH3 = 8'h20;
	localparam logic [7:0] ADDR_POL2P_CH4 = 8'h21;
	localparam logic [7:0] ADDR_REMAP = 8'h26;
	localparam logic [7:0] ADDR_PRIO12 = 8'h27;
	localparam logic [7:0] ADDR_PRIO34 = 8'h28;
	localparam logic [7:0] ADDR_POL4P12 = 8'h2A;
	localparam logic [7:0] ADDR_POL4P34 = 8'h2B;
	localparam logic [7:0] ADDR_OFF_STATUS = 8'h70;

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_REMAP = 8'hE4;
	localparam logic [7:0] RST_PRIO = 8'h00;
	localparam logic [7:0] RST_POLICE = 8'hFF;
	localparam logic [7:0] RST_GEN_MASK = 8'h00;
	localparam logic [7:0] RD_NONE = 8'h00;
	localparam int PRIO_SELECT_BIT = 7;
	localparam int ODD_LVL_LSB = 0;
	localparam int EVEN_LVL_LSB = 4;
	localparam logic [7:0] PRIO_USED_MASK = 8'h77;

	// ----------------------------------------
	// serial shutdown timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SDN_BIT_TIME_NS = 1000;
	localparam int SDN_BIT_CYCLES = SDN_BIT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [5:0] SDN_BIT_LAST = 6'(SDN_BIT_CYCLES - 1);
	localparam logic [5:0] SDN_BIT_HALF = 6'(SDN_BIT_CYCLES / 2);
	localparam logic [1:0] SDN_LAST_BIT = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} crps_bus_req_t;

	typedef struct packed {
		logic [3:0] channels;
		logic cancel_cooldown;
	} crps_off_cmd_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10
	} crps_rx_state_t;

endpackage

// ==== crps_oss_rx.sv ====
`timescale 1ns/1ps
module crps_sdn_rx import crps_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sync_clear,
	input wire logic fast_shutdown_serial_input,
	output logic [2:0] code,
	output logic code_valid
);
	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	logic meta_r;
	logic line_r;
	crps_rx_state_t state_r;
	crps_rx_state_t state_nxt;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [1:0] bit_r;
	logic [1:0] bit_nxt;
	logic [2:0] shift_r;
	logic [2:0] shift_nxt;
	logic [2:0] code_r;
	logic valid_r;
	logic mid_bit;
	logic end_bit;
	logic done;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= 1'b0;
			line_r <= 1'b0;
		end else begin
			meta_r <= fast_shutdown_serial_input;
			line_r <= meta_r;
		end
	end

	// ----------------------------------------
	// frame: start bit high, then three bits msb first
	// ----------------------------------------
	assign mid_bit = (cnt_r == SDN_BIT_HALF);
	assign end_bit = (cnt_r == SDN_BIT_LAST);
	assign done = (state_r == RX_BITS) && end_bit && (bit_r == SDN_LAST_BIT);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = end_bit ? 6'h00 : cnt_r + 6'h01;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		unique case (state_r)
			RX_IDLE: begin
				cnt_nxt = 6'h00;
				if (line_r) begin
					state_nxt = RX_START;
				end
			end
			RX_START: begin
				// a glitch shorter than half a bit is dropped
				if (mid_bit && !line_r) begin
					state_nxt = RX_IDLE;
				end else if (end_bit) begin
					state_nxt = RX_BITS;
					bit_nxt = 2'h0;
				end
			end
			RX_BITS: begin
				if (mid_bit) begin
					shift_nxt = {shift_r[1:0], line_r};
				end
				if (end_bit) begin
					bit_nxt = bit_r + 2'h1;
					if (bit_r == SDN_LAST_BIT) begin
						state_nxt = RX_IDLE;
					end
				end
			end
			default: begin
				state_nxt = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= RX_IDLE;
			cnt_r <= 6'h00;
			bit_r <= 2'h0;
			shift_r <= 3'h0;
			code_r <= 3'h0;
			valid_r <= 1'b0;
		end else if (sync_clear) begin
			state_r <= RX_IDLE;
			cnt_r <= 6'h00;
			bit_r <= 2'h0;
			shift_r <= 3'h0;
			code_r <= 3'h0;
			valid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			valid_r <= done;
			if (done) begin
				code_r <= shift_r;
			end
		end
	end

	assign code = code_r;
	assign code_valid = valid_r;
endmodule

// ==== crps_bank.sv ====
`timescale 1ns/1ps
// Summary of operation
// (R1) re-map only moves channels within this four-channel group
// (R2) re-map write ignored unless all four channels are off
// (R3) two-bit field per logical channel selects physical one; default identity
// (R4) re-map write with duplicate physical codes is rejected, mapping kept
// (R5) re-map survives pin reset; only power-on reset restores default
// (R6) host pairs only logical 1/2 and 3/4 as four-pair ports
// (R7) host should run detection and classification after re-map
// (R8) three-bit level per channel, active only when multibit select high
// (R9) odd level in bits 2:0, even in 6:4, bits 7,3 zero
// (R10) code at or below a channel's level powers it off
// (R11) code above a channel's level leaves that channel untouched
// (R12) higher level means lower priority; 111 shut by any code
// (R13) equal levels on several channels shut down together
// (R14) four-pair channels act on own levels; host sets them equal
// (R15) power-on command re-powers a channel if detection and allocation valid
// (R16) priority shutdown as channel reset but keeps cool-down timer running
// (R17) shutdown clears events, faults, class, detection, power and enable bits
// (R18) shutdown sets the channel's policing registers to all ones
// (R19) shutdown clears measurements, fault code, foldback, four-pair status
// (R20) no memory of earlier codes; each code evaluated at once
module crps_bank import crps_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reset_pin_n,
	input wire crps_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire logic fast_shutdown_serial_input,
	input wire logic [3:0] channel_off_mode,
	input wire logic [3:0] det_class_valid,
	input wire logic [3:0] alloc_sufficient,
	output crps_off_cmd_t off_cmd,
	output logic [3:0] channel_power_on_command,
	output logic [7:0] phys_map
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic map_unique(input logic [7:0] m);
		map_unique = (m[1:0] != m[3:2]) && (m[1:0] != m[5:4]) && (m[1:0] != m[7:6])
			&& (m[3:2] != m[5:4]) && (m[3:2] != m[7:6]) && (m[5:4] != m[7:6]);
	endfunction

	function automatic logic [3:0] to_physical(input logic [3:0] lg, input logic [7:0] m);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (lg[i]) begin
				p[m[2*i +: 2]] = 1'b1;
			end
		end
		to_physical = p;
	endfunction

	// ----------------------------------------
	// external reset pin, synchronised
	// ----------------------------------------
	logic rpin_meta_r;
	logic rpin_r;
	logic pin_rst;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			// idle level of the pin, so no pin reset follows power-on
			rpin_meta_r <= 1'b1;
			rpin_r <= 1'b1;
		end else begin
			rpin_meta_r <= reset_pin_n;
			rpin_r <= rpin_meta_r;
		end
	end

	assign pin_rst = !rpin_r;

	// ----------------------------------------
	// serial shutdown code receiver
	// ----------------------------------------
	logic [2:0] sdn_code;
	logic sdn_valid;

	crps_sdn_rx u_rx (
		.core_clk(core_clk),
		.rstn(rstn),
		.sync_clear(pin_rst),
		.fast_shutdown_serial_input(fast_shutdown_serial_input),
		.code(sdn_code),
		.code_valid(sdn_valid)
	);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic [7:0] remap_q;
	logic [7:0] prio12_r;
	logic [7:0] prio34_r;
	logic [7:0] gen_mask_r;
	logic [7:0] pol2p_r [4];
	logic [7:0] pol4p12_r;
	logic [7:0] pol4p34_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;
	logic wr_remap;
	logic wr_prio12;
	logic wr_prio34;
	logic wr_gen;
	logic wr_power_on;
	logic wr_chrst;
	logic wr_pol4p12;
	logic wr_pol4p34;
	logic remap_ok;
	logic prio_sel;
	logic [2:0] level [4];
	logic [3:0] prio_shut;
	logic [3:0] rst_shut;
	logic [3:0] shut_any;
	logic [3:0] pol2p_wr;

	assign wr_remap = bus_req.wr && (bus_req.addr == ADDR_REMAP);
	assign wr_prio12 = bus_req.wr && (bus_req.addr == ADDR_PRIO12);
	assign wr_prio34 = bus_req.wr && (bus_req.addr == ADDR_PRIO34);
	assign wr_gen = bus_req.wr && (bus_req.addr == ADDR_GEN_MASK);
	assign wr_power_on = bus_req.wr && (bus_req.addr == ADDR_POWER_ON);
	assign wr_chrst = bus_req.wr && (bus_req.addr == ADDR_CH_RESET);
	assign wr_pol4p12 = bus_req.wr && (bus_req.addr == ADDR_POL4P12);
	assign wr_pol4p34 = bus_req.wr && (bus_req.addr == ADDR_POL4P34);
	assign pol2p_wr[0] = bus_req.wr && (bus_req.addr == ADDR_POL2P_CH1);
	assign pol2p_wr[1] = bus_req.wr && (bus_req.addr == ADDR_POL2P_CH2);
	assign pol2p_wr[2] = bus_req.wr && (bus_req.addr == ADDR_POL2P_CH3);
	assign pol2p_wr[3] = bus_req.wr && (bus_req.addr == ADDR_POL2P_CH4);

	// ----------------------------------------
	// re-map register
	// ----------------------------------------
	// (R2) all channels off
	// (R4) duplicates rejected
	assign remap_ok = wr_remap && (&channel_off_mode) && map_unique(bus_req.wdata);

	// (R5) power-on reset only; the pin reset never reaches this flop
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			remap_q <= RST_REMAP;
		end else if (remap_ok) begin
			remap_q <= bus_req.wdata;
		end
	end

	// (R1) group-local mapping
	// (R3) field to physical
	assign phys_map = remap_q;

	// ----------------------------------------
	// priority decision
	// ----------------------------------------
	// (R8) select bit gates levels
	assign prio_sel = gen_mask_r[PRIO_SELECT_BIT];
	// (R9) odd and even level fields
	assign level[0] = prio12_r[ODD_LVL_LSB +: 3];
	assign level[1] = prio12_r[EVEN_LVL_LSB +: 3];
	assign level[2] = prio34_r[ODD_LVL_LSB +: 3];
	assign level[3] = prio34_r[EVEN_LVL_LSB +: 3];

	// (R20) no stored code; only this cycle's code counts
	// (R14) each channel uses its own level
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			// (R10) code at or below level
			// (R11) higher code ignored
			// (R12) lower level wins
			// (R13) ties shut together
			assign prio_shut[g] = sdn_valid && prio_sel && (sdn_code <= level[g]);
		end
	endgenerate

	assign rst_shut = wr_chrst ? bus_req.wdata[3:0] : 4'h0;
	assign shut_any = prio_shut | rst_shut;

	// ----------------------------------------
	// configuration and policing registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prio12_r <= RST_PRIO;
			prio34_r <= RST_PRIO;
			gen_mask_r <= RST_GEN_MASK;
		end else if (pin_rst) begin
			prio12_r <= RST_PRIO;
			prio34_r <= RST_PRIO;
			gen_mask_r <= RST_GEN_MASK;
		end else begin
			// (R9) unused bits forced to zero
			if (wr_prio12) begin
				prio12_r <= bus_req.wdata & PRIO_USED_MASK;
			end
			if (wr_prio34) begin
				prio34_r <= bus_req.wdata & PRIO_USED_MASK;
			end
			if (wr_gen) begin
				gen_mask_r <= bus_req.wdata;
			end
		end
	end

	// shutdown beats a software write in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pol2p_r <= '{default: RST_POLICE};
			pol4p12_r <= RST_POLICE;
			pol4p34_r <= RST_POLICE;
		end else if (pin_rst) begin
			pol2p_r <= '{default: RST_POLICE};
			pol4p12_r <= RST_POLICE;
			pol4p34_r <= RST_POLICE;
		end else begin
			for (int i = 0; i < 4; i++) begin
				// (R18) two-pair policing to ones
				if (shut_any[i]) begin
					pol2p_r[i] <= RST_POLICE;
				end else if (pol2p_wr[i]) begin
					pol2p_r[i] <= bus_req.wdata;
				end
			end
			// (R18) four-pair policing to ones
			if (|shut_any[1:0]) begin
				pol4p12_r <= RST_POLICE;
			end else if (wr_pol4p12) begin
				pol4p12_r <= bus_req.wdata;
			end
			if (|shut_any[3:2]) begin
				pol4p34_r <= RST_POLICE;
			end else if (wr_pol4p34) begin
				pol4p34_r <= bus_req.wdata;
			end
		end
	end

	// ----------------------------------------
	// turn-off and power-on commands
	// ----------------------------------------
	crps_off_cmd_t off_r;
	logic [3:0] power_on_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			off_r <= '0;
			power_on_r <= 4'h0;
		end else if (pin_rst) begin
			off_r <= '0;
			power_on_r <= 4'h0;
		end else begin
			// (R17) status and event clear per channel
			// (R19) measurement clear per channel
			off_r.channels <= shut_any;
			// (R16) priority shutdown leaves cool-down alone
			off_r.cancel_cooldown <= |rst_shut;
			// (R15) re-power only with valid detection and allocation
			power_on_r <= wr_power_on ?
				(bus_req.wdata[3:0] & det_class_valid & alloc_sufficient) : 4'h0;
		end
	end

	assign off_cmd = off_r;
	assign channel_power_on_command = power_on_r;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [7:0] off_status;
	logic [3:0] phys_off;

	assign phys_off = to_physical(channel_off_mode, remap_q);
	assign off_status = {phys_off, channel_off_mode};

	// write-only commands and holes read as zero
	always_comb begin
		unique case (bus_req.addr)
			ADDR_REMAP: rd_mux = remap_q;
			ADDR_PRIO12: rd_mux = prio12_r;
			ADDR_PRIO34: rd_mux = prio34_r;
			ADDR_GEN_MASK: rd_mux = gen_mask_r;
			ADDR_POL2P_CH1: rd_mux = pol2p_r[0];
			ADDR_POL2P_CH2: rd_mux = pol2p_r[1];
			ADDR_POL2P_CH3: rd_mux = pol2p_r[2];
			ADDR_POL2P_CH4: rd_mux = pol2p_r[3];
			ADDR_POL4P12: rd_mux = pol4p12_r;
			ADDR_POL4P34: rd_mux = pol4p34_r;
			ADDR_OFF_STATUS: rd_mux = off_status;
			default: rd_mux = RD_NONE;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= RD_NONE;
		end else begin
			rdata_r <= bus_req.rd ? rd_mux : RD_NONE;
		end
	end

	assign rdata = rdata_r;
endmodule

// ==== crps_oss_host.sv ====
`timescale 1ns/1ps
module crps_sdn_host import crps_pkg::*; (
	input wire logic core_clk,
	output logic fast_shutdown_serial_input
);
	// ----------------------------------------
	// serial shutdown frames
	// ----------------------------------------
	// line idles low so a stray high would look like a start bit
	initial fast_shutdown_serial_input = 1'b0;
	task automatic send_code(input logic [2:0] code);
		int b;
		@(posedge core_clk);
		fast_shutdown_serial_input <= 1'b1;
		repeat (SDN_BIT_CYCLES) @(posedge core_clk);
		for (b = 2; b >= 0; b--) begin
			fast_shutdown_serial_input <= code[b];
			repeat (SDN_BIT_CYCLES) @(posedge core_clk);
		end
		fast_shutdown_serial_input <= 1'b0;
	endtask
endmodule

// ==== crps_bank_asserts.sv ====
`timescale 1ns/1ps
module crps_bank_asserts import crps_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reset_pin_n,
	input wire crps_bus_req_t bus_req,
	input wire logic [7:0] rdata,
	input wire logic [3:0] channel_off_mode,
	input wire logic [3:0] det_class_valid,
	input wire logic [3:0] alloc_sufficient,
	input wire crps_off_cmd_t off_cmd,
	input wire logic [3:0] channel_power_on_command,
	input wire logic [7:0] phys_map
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic uniq(input logic [7:0] v);
		return v[1:0] != v[3:2] && v[1:0] != v[5:4] && v[1:0] != v[7:6] &&
			v[3:2] != v[5:4] && v[3:2] != v[7:6] && v[5:4] != v[7:6];
	endfunction
	wire remap_wr = bus_req.wr && bus_req.addr == ADDR_REMAP;
	wire rst_wr = bus_req.wr && bus_req.addr == ADDR_CH_RESET;
	wire power_on_wr = bus_req.wr && bus_req.addr == ADDR_POWER_ON;
	wire [3:0] power_on_exp = bus_req.wdata[3:0] & det_class_valid & alloc_sufficient;
	wire [3:0] wd_low = bus_req.wdata[3:0];
	wire prio_rd = bus_req.rd && (bus_req.addr == ADDR_PRIO12 || bus_req.addr == ADDR_PRIO34);
	wire uniq_wd = uniq(bus_req.wdata);
	wire map_ok = uniq(phys_map);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_remap_ok;
		remap_wr && channel_off_mode == 4'hF && uniq_wd;
	endsequence
	sequence s_serial_off;
		off_cmd.channels != 4'h0 && !$past(rst_wr);
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_remap_take:
		assert property (s_remap_ok |=> phys_map == $past(bus_req.wdata)) else $error("remap not taken");
	a_remap_busy:
		assert property (remap_wr && channel_off_mode != 4'hF |=> $stable(phys_map))
		else $error("remap taken while channels on");
	a_remap_dup:
		assert property (remap_wr && !uniq_wd |=> $stable(phys_map)) else $error("duplicate remap taken");
	a_map_group:
		assert property (map_ok) else $error("map is not a permutation of the group");
	a_map_kept:
		assert property (!reset_pin_n && !bus_req.wr |=> $stable(phys_map)) else $error("map lost on pin reset");
	a_prio_spare:
		assert property (prio_rd |=> rdata[7] == 1'b0 && rdata[3] == 1'b0) else $error("spare level bits set");
	a_power_on_gate:
		assert property (power_on_wr |=> channel_power_on_command == $past(power_on_exp))
		else $error("power-on gating wrong");
	a_reset_cmd:
		assert property (rst_wr |=> off_cmd.cancel_cooldown &&
			(off_cmd.channels & $past(wd_low)) == $past(wd_low))
		else $error("reset command turn-off wrong");
	a_keep_cooldown:
		assert property (s_serial_off |-> !off_cmd.cancel_cooldown) else $error("shutdown cancelled cool-down");
	a_shut_pulse:
		assert property (s_serial_off |=> off_cmd.channels == 4'h0 || $past(rst_wr))
		else $error("shutdown pulse repeated");
endmodule

bind crps_bank crps_bank_asserts u_chk (.core_clk(core_clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
	.bus_req(bus_req), .rdata(rdata), .channel_off_mode(channel_off_mode),
	.det_class_valid(det_class_valid), .alloc_sufficient(alloc_sufficient), .off_cmd(off_cmd),
	.channel_power_on_command(channel_power_on_command), .phys_map(phys_map));

// ==== channel_remap_and_priority_shutdown_tb.sv ====
`timescale 1ns/1ps
module channel_remap_and_priority_shutdown_tb import crps_pkg::*;;
	logic core_clk, rstn, reset_pin_n, sdn_line;
	crps_bus_req_t bus_req;
	logic [7:0] rdata, phys_map, map_m, d;
	logic [3:0] off_mode, det_ok, alloc_ok, power_on;
	crps_off_cmd_t off_cmd;
	logic [4:0] got, exp_off;
	logic [31:0] seed;
	int err_count, cmp_count, i, c;
	int lvl[4];
	logic [7:0] pol_a[6] = '{ADDR_POL2P_CH1, ADDR_POL2P_CH2, ADDR_POL2P_CH3, ADDR_POL2P_CH4,
		ADDR_POL4P12, ADDR_POL4P34};

	crps_bank dut (.core_clk(core_clk), .rstn(rstn), .reset_pin_n(reset_pin_n), .bus_req(bus_req),
		.rdata(rdata), .fast_shutdown_serial_input(sdn_line), .channel_off_mode(off_mode),
		.det_class_valid(det_ok), .alloc_sufficient(alloc_ok), .off_cmd(off_cmd),
		.channel_power_on_command(power_on), .phys_map(phys_map));
	crps_sdn_host host (.core_clk(core_clk), .fast_shutdown_serial_input(sdn_line));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic bit uniq4(input int v);
		int a, b;
		for (a = 0; a < 4; a++) for (b = a + 1; b < 4; b++)
			if (((v >> (2 * a)) & 3) == ((v >> (2 * b)) & 3)) return 0;
		return 1;
	endfunction
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 chk(what, rdata, exp);
	endtask
	// bounded poll; a missing pulse leaves zero and shows as a mismatch
	task automatic shoot(input logic [2:0] code);
		int n;
		got = 5'h00;
		fork
			host.send_code(code);
			for (n = 0; n < 200 && got == 5'h00; n++) begin
				@(posedge core_clk);
				#1 got = off_cmd;
			end
		join
	endtask
	task automatic final_report;
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		rstn = 1'b0;
		reset_pin_n = 1'b1;
		bus_req = '0;
		off_mode = 4'h0;
		det_ok = 4'h0;
		alloc_ok = 4'h0;
		err_count = 0;
		cmp_count = 0;
		seed = 32'hC03439A5;
		map_m = RST_REMAP;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (pol_a[k]) rdc("police reset", pol_a[k], RST_POLICE);
		rdc("remap reset", ADDR_REMAP, 8'hE4);
		rdc("unmapped", 8'h05, RD_NONE);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			d = i[0] ? ADDR_PRIO34 : ADDR_PRIO12;
			wr(d, seed[7:0]);
			rdc("level reg", d, seed[7:0] & 8'h77);
		end
		off_mode <= 4'h7;
		wr(ADDR_REMAP, 8'h1B);
		chk("remap busy", phys_map, map_m);
		off_mode <= 4'hF;
		for (i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			d = (i == 8) ? 8'h1B : seed[7:0];
			wr(ADDR_REMAP, d);
			if (uniq4(d)) map_m = d;
			chk("remap", phys_map, map_m);
		end
		rdc("remap read", ADDR_REMAP, map_m);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		reset_pin_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1 chk("remap kept", phys_map, map_m);
		off_mode <= 4'h2;
		rdc("status", ADDR_OFF_STATUS, {4'h1 << map_m[3:2], 4'h2});
		rdc("level after pin", ADDR_PRIO12, RST_PRIO);
		wr(ADDR_GEN_MASK, 8'h80);
		lvl = '{0, 7, 3, 3};
		wr(ADDR_PRIO12, 8'h70);
		wr(ADDR_PRIO34, 8'h33);
		for (c = 0; c < 8; c++) begin
			wr(ADDR_POL2P_CH1, 8'h12);
			wr(ADDR_POL2P_CH2, 8'h34);
			wr(ADDR_POL4P34, 8'h56);
			exp_off = 5'h00;
			for (i = 0; i < 4; i++) exp_off[i + 1] = (lvl[i] >= c);
			shoot(c[2:0]);
			chk("shutdown", {3'h0, got}, {3'h0, exp_off});
			rdc("police kept", ADDR_POL2P_CH1, (c == 0) ? RST_POLICE : 8'h12);
			rdc("police ones", ADDR_POL2P_CH2, RST_POLICE);
			rdc("pair police", ADDR_POL4P34, (c <= 3) ? RST_POLICE : 8'h56);
		end
		wr(ADDR_GEN_MASK, 8'h00);
		shoot(3'h0);
		chk("masked", {3'h0, got}, 8'h00);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			det_ok <= seed[3:0];
			alloc_ok <= seed[7:4];
			wr(ADDR_POWER_ON, seed[15:8]);
			chk("power on", {4'h0, power_on}, {4'h0, seed[11:8] & seed[3:0] & seed[7:4]});
		end
		wr(ADDR_CH_RESET, 8'h05);
		chk("reset cmd", {3'h0, off_cmd}, 8'h0B);
		final_report();
	end
endmodule
